// *** hw/msd_mode_sync.sv ***
// msd_mode_sync: enable decode, mode/sync pin decode and switching clock lock.
// assumes comparator outputs on PINS are asynchronous; registers over a plain strobe port.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`default_nettype none
module msd_mode_sync #(
  parameter int MIN_PER = msd_pkg::SYNC_MIN_PER_CYC,
  parameter int MAX_PER = msd_pkg::SYNC_MAX_PER_CYC,
  parameter int LOCK_N = msd_pkg::LOCK_EDGES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire msd_pkg::msd_pins_t PINS,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output msd_pkg::msd_ctl_t CTL,
  output logic SW_CLK
);
  import msd_pkg::*;

  // saturating increment, shared by the pin timing counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] lim);
    sat_inc = (v >= lim) ? lim : v + 16'h0001;
  endfunction

  localparam logic [15:0] TMODE = 16'(T_MODE_CYC);
  localparam logic [15:0] PER_SAT = 16'(MAX_PER + 1);
  localparam logic [15:0] RUN_SAT = 16'(LOCK_N);

  // two-flop synchroniser; first stage feeds only the second
  msd_pins_t s1_reg;
  msd_pins_t pin_reg;
  logic prev_sync_reg; // last sampled pin level, for edges
  logic rise;
  logic fall;
  logic edge_any;
  logic restart; // reset or shutdown returns control to level mode

  // enable decoder
  msd_en_state_t en_state_reg;
  msd_en_state_t en_state_next;

  // pin timing
  logic [15:0] per_cnt_reg; // cycles since last rising edge
  logic [15:0] meas_per_reg; // last valid sync period
  logic per_new_reg; // a fresh period was measured
  logic [15:0] run_reg; // rising edges in the current valid train
  logic [15:0] static_cnt_reg; // cycles since last pin edge
  logic [15:0] level_cnt_reg; // cycles with an unchanged level code
  logic [1:0] level_prev_reg;
  logic per_valid;
  logic static_fire;
  logic level_fire;

  // mode state
  logic pulse_ctrl_reg;
  logic fixed_reg; // resistor option caught, mode frozen
  logic decided_reg; // a level decision has been taken
  msd_op_t op_reg;
  logic ss_sel_reg; // spread wanted by the pin
  logic locked_reg;
  logic lock_go;

  // divider for the sync increment
  msd_div_state_t div_state_reg;
  logic [4:0] div_cnt_reg;
  logic [10:0] div_rem_reg;
  logic [15:0] div_quo_reg;
  logic [15:0] sync_inc_reg;
  logic inc_ready_reg;
  logic [10:0] div_trial;

  // oscillator
  logic [NCO_W-1:0] phase_reg;
  logic [NCO_W-1:0] inc_eff;
  logic [NCO_W:0] phase_sum;
  logic [7:0] step_reg; // phase pull-in step, software set

  // synchroniser stages
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s1_reg <= '0;
      pin_reg <= '0;
      prev_sync_reg <= 1'b0;
    end else begin
      s1_reg <= PINS;
      pin_reg <= s1_reg;
      prev_sync_reg <= pin_reg.mode_sync;
    end
  end

  // edges of the synchronised pin
  assign rise = pin_reg.mode_sync & ~prev_sync_reg;
  assign fall = ~pin_reg.mode_sync & prev_sync_reg;
  assign edge_any = rise | fall;
  assign restart = (en_state_reg == EN_SHUTDOWN);

  // enable decode; the pin is assumed always driven
  always_comb begin
    if (!pin_reg.en_wake) begin
      en_state_next = EN_SHUTDOWN;
    end else if (pin_reg.en_on && pin_reg.vin_ok) begin
      en_state_next = EN_SWITCHING;
    end else begin
      en_state_next = EN_STANDBY;
    end
  end

  // enable state register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      en_state_reg <= EN_SHUTDOWN;
    end else begin
      en_state_reg <= en_state_next;
    end
  end

  // a period is valid only inside the sync window
  assign per_valid = (per_cnt_reg >= 16'(MIN_PER)) && (per_cnt_reg <= 16'(MAX_PER));

  // period measurement and pulse train length
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      per_cnt_reg <= PER_SAT;
      meas_per_reg <= 16'h0000;
      per_new_reg <= 1'b0;
      run_reg <= 16'h0000;
    end else if (rise) begin
      per_cnt_reg <= 16'h0001;
      per_new_reg <= per_valid;
      if (per_valid) begin
        meas_per_reg <= per_cnt_reg;
        run_reg <= sat_inc(run_reg, RUN_SAT);
      end else begin
        run_reg <= 16'h0001; // first edge of a new train
      end
    end else begin
      per_cnt_reg <= sat_inc(per_cnt_reg, PER_SAT);
      per_new_reg <= 1'b0;
      if (static_fire) begin
        run_reg <= 16'h0000;
      end
    end
  end

  // hold timers for pin and level code
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      static_cnt_reg <= 16'h0000;
      level_cnt_reg <= 16'h0000;
      level_prev_reg <= LVL_GND;
    end else begin
      static_cnt_reg <= edge_any ? 16'h0000 : sat_inc(static_cnt_reg, TMODE);
      level_prev_reg <= pin_reg.mode_level;
      if (pin_reg.mode_level != level_prev_reg) begin
        level_cnt_reg <= 16'h0000;
      end else begin
        level_cnt_reg <= sat_inc(level_cnt_reg, TMODE);
      end
    end
  end

  // one-cycle fire when a hold reaches the settling time
  assign static_fire = !edge_any && (static_cnt_reg == TMODE - 16'h0001);
  assign level_fire = (pin_reg.mode_level == level_prev_reg) && (level_cnt_reg == TMODE - 16'h0001);

  // lock needs pulse control, the full train, a ready increment, normal frequency
  assign lock_go = pulse_ctrl_reg && !locked_reg && (run_reg >= RUN_SAT) && inc_ready_reg
                   && !pin_reg.freq_reduced;

  // control source: level until the fourth pulse, then pulses until restart; a fixed resistor option keeps level
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      pulse_ctrl_reg <= 1'b0;
    end else if (fall && run_reg >= 16'(PULSE_CTRL_EDGES) && !fixed_reg) begin
      pulse_ctrl_reg <= 1'b1;
    end
  end

  // resistor option latched at the first level decision only
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      fixed_reg <= 1'b0;
      decided_reg <= 1'b0;
    end else if (level_fire && !pulse_ctrl_reg && !decided_reg) begin
      decided_reg <= 1'b1;
      fixed_reg <= (pin_reg.mode_level == LVL_RES);
    end
  end

  // operating mode and spread selection
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      op_reg <= OP_AUTO;
      ss_sel_reg <= 1'b1;
      locked_reg <= 1'b0;
    end else if (!pulse_ctrl_reg) begin
      locked_reg <= 1'b0;
      if (level_fire && !fixed_reg) begin
        unique case (pin_reg.mode_level)
          LVL_GND: begin
            op_reg <= OP_AUTO;
            ss_sel_reg <= 1'b1;
          end
          LVL_RES: begin
            op_reg <= OP_AUTO;
            ss_sel_reg <= decided_reg;
          end
          LVL_MID: begin
            op_reg <= OP_FCONT;
            ss_sel_reg <= 1'b1;
          end
          LVL_HIGH: begin
            op_reg <= OP_FCONT;
            ss_sel_reg <= 1'b0;
          end
        endcase
      end
    end else if (static_fire) begin
      // static pin: level picks the mode, a lone double pulse drops spread
      op_reg <= pin_reg.mode_sync ? OP_FCONT : OP_AUTO;
      ss_sel_reg <= (run_reg != 16'(DOUBLE_PULSE_EDGES));
      locked_reg <= 1'b0;
    end else if (lock_go) begin
      op_reg <= OP_SYNC;
      locked_reg <= 1'b1;
      ss_sel_reg <= 1'b0;
    end else if (rise && !locked_reg && run_reg == 16'h0000) begin
      ss_sel_reg <= 1'b1;
    end
  end

  // serial restoring divide: increment = 2^16 / period
  assign div_trial = {div_rem_reg[9:0], (div_cnt_reg == 5'h10)};
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      div_state_reg <= DIV_IDLE;
      div_cnt_reg <= 5'h00;
      div_rem_reg <= 11'h000;
      div_quo_reg <= 16'h0000;
    end else begin
      unique case (div_state_reg)
        DIV_IDLE: begin
          if (per_new_reg) begin
            div_state_reg <= DIV_RUN;
            div_cnt_reg <= 5'h10;
            div_rem_reg <= 11'h000;
            div_quo_reg <= 16'h0000;
          end
        end
        DIV_RUN: begin
          if (div_trial >= meas_per_reg[10:0]) begin
            div_rem_reg <= div_trial - meas_per_reg[10:0];
            div_quo_reg <= {div_quo_reg[14:0], 1'b1};
          end else begin
            div_rem_reg <= div_trial;
            div_quo_reg <= {div_quo_reg[14:0], 1'b0};
          end
          if (div_cnt_reg == 5'h00) begin
            div_state_reg <= DIV_IDLE;
          end else begin
            div_cnt_reg <= div_cnt_reg - 5'h01;
          end
        end
      endcase
    end
  end

  // latest finished quotient; frozen while locked so the period stays put
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || restart) begin
      sync_inc_reg <= NCO_DEF_INC;
      inc_ready_reg <= 1'b0;
    end else if (div_state_reg == DIV_RUN && div_cnt_reg == 5'h00 && !locked_reg) begin
      sync_inc_reg <= (div_trial >= meas_per_reg[10:0]) ? {div_quo_reg[14:0], 1'b1}
                                                         : {div_quo_reg[14:0], 1'b0};
      inc_ready_reg <= 1'b1;
    end
  end

  // effective increment with phase pull-in on each sync rising edge while locked
  always_comb begin
    inc_eff = NCO_DEF_INC;
    if (locked_reg) begin
      inc_eff = sync_inc_reg;
      if (rise && phase_reg[NCO_W-1] && (phase_reg < 16'hFFFF - 16'(step_reg))) begin
        inc_eff = sync_inc_reg + 16'(step_reg);
      end else if (rise && !phase_reg[NCO_W-1] && (phase_reg > 16'(step_reg))) begin
        inc_eff = sync_inc_reg - 16'(step_reg);
      end
    end
  end

  // phase accumulator: a new increment keeps the phase, so one mid-length cycle
  assign phase_sum = {1'b0, phase_reg} + {1'b0, inc_eff};
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || en_state_reg != EN_SWITCHING) begin
      phase_reg <= 16'h0000;
      SW_CLK <= 1'b0;
    end else begin
      phase_reg <= phase_sum[NCO_W-1:0];
      SW_CLK <= phase_sum[NCO_W];
    end
  end

  // controls to the power stage, registered
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      CTL <= '0;
    end else begin
      CTL.supply_on <= (en_state_reg != EN_SHUTDOWN);
      CTL.switch_en <= (en_state_reg == EN_SWITCHING);
      CTL.pulse_skipping_operation <= (op_reg == OP_AUTO);
      CTL.diode_emul_en <= (op_reg == OP_AUTO);
      CTL.forced_continuous_operation <= (op_reg != OP_AUTO);
      // slowed clock overrides spread until it ends
      CTL.spread_en <= ss_sel_reg && !pin_reg.foldback && !pin_reg.freq_reduced
                       && (en_state_reg == EN_SWITCHING);
      CTL.sync_locked <= locked_reg;
      CTL.pulse_ctrl <= pulse_ctrl_reg;
    end
  end

  // configuration register write
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      step_reg <= PHASE_STEP_RST;
    end else if (WR && ADDR == ADDR_CFG) begin
      step_reg <= WDATA[7:0];
    end
  end

  // read port, data one cycle after the strobe only
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || !RD) begin
      RDATA <= 32'h00000000;
    end else begin
      unique case (ADDR)
        ADDR_STATUS: begin
          RDATA <= 32'h00000000;
          RDATA[ST_EN_LSB +: 2] <= en_state_reg;
          RDATA[ST_OP_LSB +: 2] <= op_reg;
          RDATA[ST_SS] <= ss_sel_reg;
          RDATA[ST_LOCK] <= locked_reg;
          RDATA[ST_PULSE] <= pulse_ctrl_reg;
          RDATA[ST_FIXED] <= fixed_reg;
        end
        ADDR_PERIOD: RDATA <= {16'h0000, meas_per_reg};
        ADDR_RUN: RDATA <= {16'h0000, run_reg};
        ADDR_CFG: RDATA <= {24'h000000, step_reg};
        default: RDATA <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/msd_pkg.sv ***
// msd_pkg: constants, enumerations and carrier structs of the mode/sync pin decoder.
// assumes a 50 MHz core clock; analog comparators outside deliver the digital levels.
`default_nettype none
package msd_pkg;
  // core clock
  localparam int CLK_PERIOD_NS = 20;
  // mode settling time, least time, so rounded up
  localparam int T_MODE_NS = 20000;
  localparam int T_MODE_CYC = (T_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pulse counts of the pin protocol
  localparam int PULSE_CTRL_EDGES = 4;
  localparam int DOUBLE_PULSE_EDGES = 2;
  localparam int LOCK_EDGES = 2048;
  // valid sync period window in core cycles (defaults only)
  localparam int SYNC_MIN_PER_CYC = 4;
  localparam int SYNC_MAX_PER_CYC = 512;
  // switching clock oscillator
  localparam int NCO_W = 16;
  localparam logic [15:0] NCO_DEF_INC = 16'h0AAB;
  localparam logic [7:0] PHASE_STEP_RST = 8'h01;
  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_RUN = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;
  // status field positions
  localparam int ST_EN_LSB = 0;
  localparam int ST_OP_LSB = 2;
  localparam int ST_SS = 4;
  localparam int ST_LOCK = 5;
  localparam int ST_PULSE = 6;
  localparam int ST_FIXED = 7;
  // level comparator codes of the mode pin
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_RES = 2'h1;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  typedef enum logic [1:0] {EN_SHUTDOWN, EN_STANDBY, EN_SWITCHING} msd_en_state_t;
  typedef enum logic [1:0] {OP_AUTO, OP_FCONT, OP_SYNC} msd_op_t;
  typedef enum logic {DIV_IDLE, DIV_RUN} msd_div_state_t;
  // pins and comparator outputs, all asynchronous to the core clock
  typedef struct packed {
    logic en_wake;
    logic en_on;
    logic vin_ok;
    logic mode_sync;
    logic [1:0] mode_level;
    logic foldback;
    logic freq_reduced;
  } msd_pins_t;
  // controls to the power stage
  typedef struct packed {
    logic supply_on;
    logic switch_en;
    logic pulse_skipping_operation;
    logic diode_emul_en;
    logic forced_continuous_operation;
    logic spread_en;
    logic sync_locked;
    logic pulse_ctrl;
  } msd_ctl_t;
endpackage
`default_nettype wire

// *** verif/msd_mode_sync_chk.sv ***
// msd_mode_sync_chk: port-level assertions of the mode/sync pin decoder.
// assumes one core clock domain; bound onto every msd_mode_sync instance.
`default_nettype none
module msd_mode_sync_chk
  import msd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire msd_pkg::msd_pins_t PINS,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire msd_pkg::msd_ctl_t CTL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  // six samples cover two synchroniser flops, state and output registers
  sequence s_en_full;
    (PINS.en_wake && PINS.en_on && PINS.vin_ok) [*6];
  endsequence
  sequence s_en_low;
    !PINS.en_wake [*6];
  endsequence
  a_shut_all_off: assert property (s_en_low |-> !CTL.supply_on && !CTL.switch_en)
    else $error("supply or switching active in shutdown");
  a_standby_noswitch: assert property ((PINS.en_wake && !PINS.en_on) [*6] |-> CTL.supply_on && !CTL.switch_en)
    else $error("standby outputs wrong");
  a_switch_on: assert property (s_en_full |-> CTL.supply_on && CTL.switch_en)
    else $error("switching not started");
  a_auto_diode: assert property (CTL.pulse_skipping_operation |->
    CTL.diode_emul_en && !CTL.forced_continuous_operation)
    else $error("auto mode without diode emulation");
  a_fcont_nodiode: assert property (CTL.forced_continuous_operation |-> !CTL.diode_emul_en)
    else $error("diode emulation in forced mode");
  a_level_nosync: assert property (!CTL.pulse_ctrl |-> !CTL.sync_locked)
    else $error("locked under level control");
  a_sync_nospread: assert property (CTL.sync_locked |-> !CTL.spread_en && !CTL.diode_emul_en)
    else $error("spread or emulation while locked");
  a_fold_nospread: assert property (PINS.foldback [*6] |-> !CTL.spread_en)
    else $error("spread active in foldback");
  // only a shutdown may drop pulse control
  a_pulse_sticky: assert property ((PINS.en_wake [*6] ##0 CTL.pulse_ctrl) |=> CTL.pulse_ctrl)
    else $error("pulse control lost without restart");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside answer cycle");
endmodule
bind msd_mode_sync msd_mode_sync_chk u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PINS(PINS), .RD(RD),
  .RDATA(RDATA), .CTL(CTL));
`default_nettype wire

// *** verif/msd_sync_host.sv ***
// msd_sync_host: behavioural model of the logic driving the mode/sync line.
// assumes one train at a time; the line has no pull, so it always holds a driven level.
`default_nettype none
module msd_sync_host (
  output logic SYNC_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // line rests low until the first train
  initial SYNC_OUT = 1'b0;
  // n rising edges at 160 ns, half duty, then the line rests at lvl
  task automatic send(input int n, input logic lvl);
    SYNC_OUT = 1'b0;
    #57; // odd offset keeps the train out of phase with the core clock
    for (int i = 0; i < n; i++) begin
      SYNC_OUT = 1'b1;
      #80;
      // a high rest keeps the last pulse up; a fall here would add an (n+1)th rise
      if (i < n - 1 || lvl == 1'b0) begin
        SYNC_OUT = 1'b0;
        #80;
      end
    end
    SYNC_OUT = lvl;
  endtask
endmodule
`default_nettype wire

// *** verif/msd_mode_sync_tb.sv ***
// msd_mode_sync_tb: self-checking bench of the mode/sync pin decoder.
// assumes msd_pkg, msd_mode_sync, the checker and the host model compiled before it.
`default_nettype none
module msd_mode_sync_tb;
  import msd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0; // low while in reset
  msd_pins_t pins_drv; // levels from the bench
  msd_pins_t pins; // bundle seen by the block
  logic sync_line; // driven by the host model
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  msd_ctl_t ctl;
  logic sw_clk; // switching clock pulses from the block
  logic [31:0] d; // last word read
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  // host line replaces the bench's copy
  always_comb begin
    pins = pins_drv;
    pins.mode_sync = sync_line;
  end
  msd_sync_host host (.SYNC_OUT(sync_line));
  // short lock count keeps the run brief
  msd_mode_sync #(.LOCK_N(16)) dut (.CORE_CLK(core_clk), .RST_B(rst_b), .PINS(pins), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CTL(ctl), .SW_CLK(sw_clk));
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // settle past the edge before looking
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // skip, forced, spread as one code
  task automatic mode3(input logic [2:0] e);
    chk({29'h0, ctl.pulse_skipping_operation, ctl.forced_continuous_operation, ctl.spread_en}, {29'h0, e});
  endtask
  task automatic bit1(input logic b, input logic e);
    chk({31'h0, b}, {31'h0, e});
  endtask
  // switching pulses over n cycles; nudges and start phase allow one either way
  task automatic sw_rate(input int n, input int lo, input int hi);
    int k;
    k = 0;
    repeat (n) begin
      cyc(1);
      if (sw_clk) begin
        k++;
      end
    end
    chk({31'h0, (k >= lo && k <= hi)}, 32'h1);
  endtask
  // registers, then enable thresholds
  task automatic t_regs_enable();
    rreg(ADDR_CFG);
    chk(d, {24'h0, PHASE_STEP_RST});
    wreg(ADDR_CFG, 32'h0000_005A);
    wreg(ADDR_STATUS, 32'hFFFF_FFFF);
    rreg(ADDR_CFG);
    chk(d, 32'h0000_005A);
    rreg(8'h10);
    chk(d, 32'h0);
    rreg(ADDR_STATUS);
    chk({30'h0, d[1:0]}, 32'h0);
    chk({30'h0, ctl.supply_on, ctl.switch_en}, 32'h0);
    @(posedge core_clk) pins_drv.en_wake <= 1'b1;
    cyc(8);
    chk({30'h0, ctl.supply_on, ctl.switch_en}, 32'h2);
    @(posedge core_clk) pins_drv.en_on <= 1'b1;
    cyc(8);
    chk({30'h0, ctl.supply_on, ctl.switch_en}, 32'h2);
    @(posedge core_clk) pins_drv.vin_ok <= 1'b1;
    cyc(8);
    chk({30'h0, ctl.supply_on, ctl.switch_en}, 32'h3);
    rreg(ADDR_STATUS);
    chk({30'h0, d[1:0]}, 32'h2);
    // default increment wraps about every 24 cycles, so ten in 240
    sw_rate(240, 9, 11);
  endtask
  // mid, high and ground levels; high and ground checked unapplied before the settling time
  task automatic t_level();
    logic [1:0] lv [3];
    logic [2:0] ex [3];
    lv = '{LVL_MID, LVL_HIGH, LVL_GND};
    ex = '{3'b011, 3'b010, 3'b101};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) pins_drv.mode_level <= lv[i];
      cyc(T_MODE_CYC - 100);
      if (i > 0) begin
        mode3(ex[i - 1]);
      end
      cyc(200);
      mode3(ex[i]);
      bit1(ctl.diode_emul_en, ex[i][2]);
    end
    @(posedge core_clk) pins_drv.foldback <= 1'b1;
    cyc(8);
    mode3(3'b100);
    @(posedge core_clk) pins_drv.foldback <= 1'b0;
    cyc(8);
    mode3(3'b101);
  endtask
  // entry to pulse control, static levels and double pulses
  task automatic t_pulse();
    host.send(4, 1'b0);
    cyc(T_MODE_CYC + 100);
    bit1(ctl.pulse_ctrl, 1'b1);
    mode3(3'b101);
    host.send(2, 1'b0);
    cyc(T_MODE_CYC + 100);
    mode3(3'b100);
    @(posedge core_clk) pins_drv.mode_level <= LVL_HIGH;
    host.send(0, 1'b1);
    cyc(T_MODE_CYC - 100);
    chk({30'h0, ctl.pulse_skipping_operation, ctl.forced_continuous_operation}, 32'h2);
    cyc(200);
    mode3(3'b011);
    host.send(2, 1'b1);
    cyc(T_MODE_CYC + 100);
    mode3(3'b010);
  endtask
  // lock to a running clock, then with lock held off
  task automatic t_sync();
    fork
      host.send(40, 1'b0);
    join_none
    cyc(48);
    bit1(ctl.spread_en, 1'b1);
    bit1(ctl.sync_locked, 1'b0);
    cyc(200);
    bit1(ctl.sync_locked, 1'b1);
    bit1(ctl.spread_en, 1'b0);
    rreg(ADDR_PERIOD);
    chk(d, 32'h8);
    rreg(ADDR_STATUS);
    chk({30'h0, d[3:2]}, 32'h2);
    // locked to an 8-cycle sync clock: ten pulses in 80 cycles
    sw_rate(80, 9, 11);
    wait fork;
    cyc(T_MODE_CYC + 100);
    mode3(3'b101);
    chk({30'h0, ctl.pulse_ctrl, ctl.sync_locked}, 32'h2);
    @(posedge core_clk) pins_drv.freq_reduced <= 1'b1;
    fork
      host.send(40, 1'b0);
    join_none
    cyc(248);
    bit1(ctl.sync_locked, 1'b0);
    @(posedge core_clk) pins_drv.freq_reduced <= 1'b0;
    cyc(30);
    bit1(ctl.sync_locked, 1'b1);
    wait fork;
    cyc(T_MODE_CYC + 100);
  endtask
  // restart, then the fixed resistor option
  task automatic t_restart();
    @(posedge core_clk);
    pins_drv.en_wake <= 1'b0;
    pins_drv.mode_level <= LVL_RES;
    cyc(10);
    @(posedge core_clk) pins_drv.en_wake <= 1'b1;
    cyc(T_MODE_CYC + 100);
    bit1(ctl.pulse_ctrl, 1'b0);
    mode3(3'b100);
    rreg(ADDR_STATUS);
    bit1(d[ST_FIXED], 1'b1);
    @(posedge core_clk) pins_drv.mode_level <= LVL_HIGH;
    host.send(4, 1'b0);
    cyc(T_MODE_CYC + 100);
    mode3(3'b100);
  endtask
  initial begin
    pins_drv = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs_enable();
    t_level();
    t_pulse();
    t_sync();
    t_restart();
    wrap_up();
  end
  // hang guard, well above the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
